//--- hw/odt_ctrl.sv
// Termination control logic: on/off latency and dynamic strength
`timescale 1ns/1ps

// Overview of operation
// [RULE1] Controller holds input high four clocks
// [RULE2] Write with input high: hold four/six
// [RULE3] Controller meets both hold windows together
// [RULE4] Controller lowers input around read bursts
// [RULE5] Termination returns when output drive stops
// [RULE6] Dynamic switching on if write bits nonzero
// [RULE7] Nominal and write values from mode bits
// [RULE8] No write: nominal strength when on
// [RULE9] On/off follows input after latency
// [RULE10] Write strength at write latency minus two
// [RULE11] Back to nominal off-latency plus four/six
// [RULE12] Strength change lands half clock late
// [RULE13] Controller zeroes write bits with loop off
// [RULE14] Frozen loop in power-down: asynchronous mode
// [RULE15] Asynchronous mode ignores additive latency
// [RULE16] Asynchronous change within 2 to 8.5 ns
// [RULE17] Input receiver stays live in power-down
// [RULE18] Disabled values or self-refresh ignore input
// [RULE19] Locked loop uses synchronous timing
// [RULE20] Synchronous latency adds additive latency
// [RULE21] Dynamic off keeps nominal through writes
module odt_ctrl
  import odt_pkg::*;
#(
  parameter int unsigned PW = PIPE_W       // Delay line depth
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_term_ctl,      // termination_control_input
  input  wire logic       i_wr_cmd,        // Write command registered
  input  wire logic       i_wr_chop,       // Write is four_beat_chop
  input  wire logic [4:0] i_write_lat,     // column_write_latency
  input  wire logic [4:0] i_add_lat,       // additive_latency
  input  wire logic [12:0] i_mode_first,   // first_mode_word
  input  wire logic [12:0] i_mode_nom,     // second_mode_word_nominal
  input  wire logic [12:0] i_mode_dyn,     // third_mode_word_dynamic
  input  wire logic       i_pd_pre,        // In precharge power-down
  input  wire logic       i_self_ref,      // In self-refresh
  input  wire logic       i_drive_dq,      // Device drives data lines
  output logic            o_term_on,       // Termination enabled
  output logic [1:0]      o_strength,      // STR_* select
  output logic [2:0]      o_nom_val,       // Nominal value code
  output logic [1:0]      o_wr_val,        // Write value code
  output logic            o_async_mode,    // Asynchronous timing active
  output logic            o_hold_viol      // Controller broke a hold
);

  // Module state, all but the value code registers, in one struct
  typedef struct packed {
    logic [PW-1:0] on_pipe;   // Delayed control input
    logic [PW-1:0] wr_pipe;   // Delayed write start markers
    logic [PW-1:0] end_pipe;  // Delayed burst write end markers
    logic [PW-1:0] chop_pipe; // Delayed chop write end markers
    logic [3:0]    async_cnt; // Asynchronous delay counter
    logic          async_tgt; // Asynchronous pending level
    logic          in_write;  // Write strength active
    logic          term_on;
    logic [1:0]    strength;
    logic          async_md;
    logic [2:0]    hold_cnt;  // Remaining hold clocks
    logic          ctl_prev;
    logic          viol;
  } odt_st_t;

  odt_st_t st_r;
  odt_st_t st_nxt;

  // Tap index from latency, clamped to the delay line
  function automatic logic [4:0] tap(input logic [5:0] lat);
    tap = (lat >= 6'(PW)) ? 5'(PW - 1) : lat[4:0];
  endfunction

  logic [2:0] nom_val;
  logic [1:0] wr_val;
  logic       dyn_en;
  logic       odt_en;
  logic [5:0] lat_sync;
  logic [5:0] lat_chop;  // Write to nominal, chop writes
  logic [5:0] lat_burst; // Write to nominal, full bursts

  // Mode word decode
  always_comb begin
    nom_val = {i_mode_nom[NOM_B2], i_mode_nom[NOM_B1],
               i_mode_nom[NOM_B0]};                          // RULE7
    wr_val  = {i_mode_dyn[WR_B1], i_mode_dyn[WR_B0]};       // RULE7
    dyn_en  = |wr_val;                                       // RULE6
    odt_en  = ((|nom_val) || (|wr_val)) && !i_self_ref;      // RULE18
    // Clamp below offset; short latencies bottom out at zero
    lat_sync = 6'(i_write_lat) + 6'(i_add_lat);              // RULE20
    lat_sync = (lat_sync > 6'(LAT_OFFSET)) ?
               lat_sync - 6'(LAT_OFFSET) : 6'h00;            // RULE9
    lat_chop  = lat_sync + 6'(CWN_CHOP_ADD);                 // RULE11
    lat_burst = lat_sync + 6'(CWN_BURST_ADD);                // RULE11
  end

  // Next-state logic
  //
  // Timing model in short:
  // - The control input is gated by the enable decode and shifted
  //   into a delay line; the tap at the synchronous latency drives
  //   the on/off register one clock later.
  // - A write drops a start marker into one line and an end marker
  //   into a second or third line, picked by the write kind at the
  //   moment the command is taken. The chop qualifier is only valid
  //   with the command, so it cannot be looked at again later.
  // - Strength is registered once more behind on/off and in_write;
  //   that extra stage stands for the half-clock change skew.
  // - In asynchronous mode the delay lines are bypassed and a small
  //   counter gives the fixed nanosecond delay instead.
  // Limitation: latencies past the delay line depth clamp to the
  // last tap, so very long settings respond early.
  // Trade-off: one deep shift line per event kind costs flops but
  // lets any number of windows overlap without counters colliding.
  always_comb begin
    logic ctl;
    logic wr_go;
    logic wr_done;
    logic wr_ok;
    ctl = i_term_ctl && odt_en;                              // RULE18
    // Writes cannot occur in power-down; gate anyway
    wr_ok = i_wr_cmd && !i_pd_pre;                           // RULE17
    wr_go = st_r.wr_pipe[tap(lat_sync)];                     // RULE10
    // Either kind of end marker reaching its tap ends the write
    wr_done = st_r.chop_pipe[tap(lat_chop)] ||
              st_r.end_pipe[tap(lat_burst)];                 // RULE11
    st_nxt = st_r;
    // Frozen loop in precharge power-down selects async timing
    st_nxt.async_md = i_pd_pre && !i_mode_first[DLL_FRZ_B];  // RULE14 RULE19
    st_nxt.on_pipe = {st_r.on_pipe[PW-2:0], ctl};
    st_nxt.wr_pipe = {st_r.wr_pipe[PW-2:0], wr_ok};
    // End markers split by write kind as the command is taken
    st_nxt.end_pipe = {st_r.end_pipe[PW-2:0], wr_ok && !i_wr_chop};
    st_nxt.chop_pipe = {st_r.chop_pipe[PW-2:0], wr_ok && i_wr_chop};
    if (st_r.async_md) begin
      // No additive latency; fixed nanosecond delay
      st_nxt.in_write = 1'b0;
      if (ctl != st_r.async_tgt) begin                       // RULE15
        st_nxt.async_tgt = ctl;
        st_nxt.async_cnt = 4'(ASYNC_CYC);
      end else if (st_r.async_cnt > 4'h1) begin
        st_nxt.async_cnt = st_r.async_cnt - 4'h1;
      end else begin
        st_nxt.term_on = st_r.async_tgt;                     // RULE16
      end
    end else begin
      st_nxt.async_tgt = ctl;
      st_nxt.async_cnt = 4'h0;
      // Synchronous on/off after latency
      st_nxt.term_on = st_r.on_pipe[tap(lat_sync)];          // RULE9
      if (wr_go && dyn_en) begin                             // RULE21
        st_nxt.in_write = 1'b1;                              // RULE10
      end else if (wr_done || !dyn_en) begin
        st_nxt.in_write = 1'b0;                              // RULE11
      end
    end
    // Output is released while the device drives data
    if (i_drive_dq) begin
      st_nxt.term_on = 1'b0;                                 // RULE5
    end
    // Strength: registered stage is the half-clock skew point
    if (!st_r.term_on) begin
      st_nxt.strength = STR_OFF;                             // RULE12
    end else if (st_r.in_write) begin
      st_nxt.strength = STR_WR;                              // RULE10
    end else begin
      st_nxt.strength = STR_NOM;                             // RULE8
    end
    // Watch controller hold windows, both at once
    st_nxt.ctl_prev = i_term_ctl;
    if (i_term_ctl && !st_r.ctl_prev) begin
      st_nxt.hold_cnt = 3'(HOLD_SHORT_CYC - 1);              // RULE1
    end else if (st_r.hold_cnt != 3'h0) begin
      st_nxt.hold_cnt = st_r.hold_cnt - 3'h1;
    end
    if (i_wr_cmd && i_term_ctl) begin
      st_nxt.hold_cnt = i_wr_chop ? 3'(HOLD_SHORT_CYC - 1)
                                  : 3'(HOLD_LONG_CYC - 1);   // RULE2 RULE3
    end
    if (!i_term_ctl && st_r.hold_cnt != 3'h0) begin
      st_nxt.viol = 1'b1;                                    // RULE3
      st_nxt.hold_cnt = 3'h0;
    end else begin
      st_nxt.viol = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Value codes registered too, so outputs come from flops
  logic [2:0] nom_val_r;
  logic [1:0] wr_val_r;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      nom_val_r <= 3'h0;
      wr_val_r  <= 2'h0;
    end else begin
      nom_val_r <= nom_val;
      wr_val_r  <= wr_val;
    end
  end

  assign o_term_on    = st_r.term_on;
  assign o_strength   = st_r.strength;
  assign o_nom_val    = nom_val_r;
  assign o_wr_val     = wr_val_r;
  assign o_async_mode = st_r.async_md;
  assign o_hold_viol  = st_r.viol;

endmodule

//--- hw/odt_pkg.sv
// Package: constants for the termination control block
package odt_pkg;
  // Hold windows on the control input, in clocks
  localparam int unsigned HOLD_SHORT_CYC = 4;   // term_hold_short
  localparam int unsigned HOLD_LONG_CYC  = 6;   // term_hold_long
  // Extra clocks after turn-off latency to return to nominal strength
  localparam int unsigned CWN_CHOP_ADD   = 4;
  localparam int unsigned CWN_BURST_ADD  = 6;
  // Latency offset: on/off latency = write latency + additive - 2
  localparam int unsigned LAT_OFFSET     = 2;
  // Clock period and asynchronous delays
  localparam int unsigned CLK_PS         = 5000;
  localparam int unsigned ASYNC_MIN_PS   = 2000;
  localparam int unsigned ASYNC_MAX_PS   = 8500;
  // Least time rounds up, longest rounds down; least time used, capped at longest
  localparam int unsigned ASYNC_MIN_CYC  =
    (ASYNC_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned ASYNC_MAX_CYC  = ASYNC_MAX_PS / CLK_PS;
  localparam int unsigned ASYNC_CYC      =
    (ASYNC_MIN_CYC > ASYNC_MAX_CYC) ? ASYNC_MAX_CYC : ASYNC_MIN_CYC;
  // Mode word field positions
  localparam int unsigned NOM_B0 = 2;
  localparam int unsigned NOM_B1 = 6;
  localparam int unsigned NOM_B2 = 9;
  localparam int unsigned WR_B0  = 9;
  localparam int unsigned WR_B1  = 10;
  localparam int unsigned DLL_FRZ_B = 12;
  // Strength select encodings
  localparam logic [1:0] STR_OFF = 2'h0;
  localparam logic [1:0] STR_NOM = 2'h1;
  localparam logic [1:0] STR_WR  = 2'h2;
  localparam int unsigned PIPE_W = 32;
endpackage

//--- dv/odt_monitor.sv
// Checker of termination timing at the control block's ports
`timescale 1ns/1ps
module odt_monitor
  import odt_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_term_ctl,
  input wire logic        i_wr_cmd,
  input wire logic        i_wr_chop,
  input wire logic [4:0]  i_write_lat,
  input wire logic [4:0]  i_add_lat,
  input wire logic [12:0] i_mode_first,
  input wire logic [12:0] i_mode_nom,
  input wire logic [12:0] i_mode_dyn,
  input wire logic        i_pd_pre,
  input wire logic        i_self_ref,
  input wire logic        i_drive_dq,
  input wire logic        o_term_on,
  input wire logic [1:0]  o_strength,
  input wire logic [2:0]  o_nom_val,
  input wire logic [1:0]  o_wr_val,
  input wire logic        o_async_mode,
  input wire logic        o_hold_viol
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic dy;  // Dynamic switching bits set
  logic ok;  // Latency three, enabled, no read, no power-down
  logic as;  // Frozen loop in power-down, enabled
  assign dy = |i_mode_dyn[10:9];
  assign ok = i_write_lat == 5'h05 && i_add_lat == 5'h00 && !i_pd_pre &&
    !i_self_ref && !i_drive_dq && |{i_mode_nom[9], i_mode_nom[6], i_mode_nom[2]};
  assign as = i_pd_pre && !i_mode_first[12] && !i_self_ref && !i_drive_dq &&
    |{i_mode_nom[9], i_mode_nom[6], i_mode_nom[2]};
  AST_ON: assert property ($rose(i_term_ctl) && ok ##1
    (ok && i_term_ctl)[*4] |-> ##1 o_term_on) else $error("late turn-on");
  AST_OFF: assert property ($fell(i_term_ctl) && ok ##1
    (ok && !i_term_ctl)[*4] |-> ##1 !o_term_on) else $error("late turn-off");
  AST_VAL: assert property (($stable(i_mode_nom) && $stable(i_mode_dyn))[*3]
    |-> o_nom_val == {i_mode_nom[9], i_mode_nom[6], i_mode_nom[2]} &&
    o_wr_val == i_mode_dyn[10:9]) else $error("value code wrong");
  AST_NOM: assert property ((!dy)[*8] ##1 (!dy)[*3] ##1 (!dy && o_term_on)
    |=> o_strength == STR_NOM) else $error("not nominal strength");
  AST_WR: assert property (i_wr_cmd && !i_wr_chop && dy && ok && i_term_ctl
    ##1 (ok && dy && i_term_ctl && !i_wr_cmd)[*6] |-> ##5 o_strength == STR_WR
    ##1 o_strength == STR_NOM) else $error("write strength timing");
  AST_ASY: assert property (as && $rose(i_term_ctl) ##1 (as && i_term_ctl)
    |-> ##[0:1] (o_term_on && o_async_mode)) else $error("async turn-on");
  AST_DRV: assert property (i_drive_dq |=> !o_term_on)
    else $error("on while driving");
  AST_HOLD: assert property ($rose(i_term_ctl) && ok ##1 i_term_ctl ##1
    !i_term_ctl |=> o_hold_viol) else $error("short hold missed");
endmodule
bind odt_ctrl odt_monitor mon (.*);

//--- dv/odt_ctl_model.sv
// Memory controller model driving the termination pin and writes
`timescale 1ns/1ps
module odt_ctl_model (
  input  wire logic i_mclk,
  input  wire logic i_go,          // Open a termination window
  input  wire logic i_wr,          // Write on the window's first clock
  input  wire logic i_chop,        // That write is a four_beat_chop
  input  wire logic i_bad,         // Drop the pin early on purpose
  output logic      o_ctl,         // termination_control_input
  output logic      o_wr = 1'h0,   // Write command pulse
  output logic      o_chop = 1'h0  // Chop qualifier, follows i_chop on the request clock
);
  logic [3:0] cnt_r = 4'h0;  // Clocks left with the pin high
  // Eight clocks covers both hold windows at once; no reads issued
  // so the pin never has to drop around a read burst
  always @(posedge i_mclk) begin
    if (i_go)
      cnt_r <= i_bad ? 4'h2 : 4'h8;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
    o_wr <= i_go & i_wr;
    o_chop <= i_go & i_chop;
  end
  assign o_ctl = cnt_r != 4'h0;
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the termination control block
`timescale 1ns/1ps
module tb_top;
  import odt_pkg::*;
  typedef struct {logic [12:0] n, d; logic w, c, s; logic [2:0] en;
    logic [1:0] ew, es; logic eo;} odt_row_t;
  // Mode words, write kind, self-refresh; expected codes, strength, on
  odt_row_t rows[6] = '{
    '{13'h0005, 13'h0000, 1'h1, 1'h0, 1'h0, 3'h1, 2'h0, 2'h1, 1'h1},
    '{13'h0240, 13'h0200, 1'h1, 1'h1, 1'h0, 3'h6, 2'h1, 2'h2, 1'h1},
    '{13'h0000, 13'h0400, 1'h1, 1'h0, 1'h0, 3'h0, 2'h2, 2'h2, 1'h1},
    '{13'h0244, 13'h0600, 1'h0, 1'h0, 1'h0, 3'h7, 2'h3, 2'h1, 1'h1},
    '{13'h0000, 13'h1000, 1'h0, 1'h0, 1'h0, 3'h0, 2'h0, 2'h0, 1'h0},
    '{13'h0004, 13'h0000, 1'h0, 1'h0, 1'h1, 3'h1, 2'h0, 2'h0, 1'h0}};
  logic clk = 0, rst = 1, go = 0, gwr = 0, gch = 0, bad = 0;
  logic pd = 0, sr = 0, dq = 0, ctl, wr, ch, on, av, hv;
  logic [4:0] wl = 5'h05, al = 5'h00;
  logic [12:0] mf = 13'h1000, mn = 13'h0000, md = 13'h0000;
  logic [1:0] st, wv;
  logic [2:0] nv;
  int n_fail = 0, num_checks = 0, k;
  initial forever #2.5 clk = ~clk;
  odt_ctl_model far (.i_mclk(clk), .i_go(go), .i_wr(gwr), .i_chop(gch),
    .i_bad(bad), .o_ctl(ctl), .o_wr(wr), .o_chop(ch));
  odt_ctrl uut (.i_mclk(clk), .i_rst(rst), .i_term_ctl(ctl), .i_wr_cmd(wr),
    .i_wr_chop(ch), .i_write_lat(wl), .i_add_lat(al), .i_mode_first(mf),
    .i_mode_nom(mn), .i_mode_dyn(md), .i_pd_pre(pd), .i_self_ref(sr),
    .i_drive_dq(dq), .o_term_on(on), .o_strength(st), .o_nom_val(nv),
    .o_wr_val(wv), .o_async_mode(av), .o_hold_viol(hv));
  // Let n edges land, then sample settled outputs
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic [2:0] got, logic [2:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One-clock request to the controller model
  task automatic win(logic w, logic c, logic b);
    @(posedge clk);
    {go, gwr, gch, bad} <= {1'h1, w, c, b};
    @(posedge clk);
    go <= 1'h0;
  endtask
  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    cyc(1);
    chk({on, st}, 3'h0);
    foreach (rows[i]) begin
      @(posedge clk);
      {mn, md, sr} <= {rows[i].n, rows[i].d, rows[i].s};
      cyc(3);
      chk(nv, rows[i].en);
      chk({1'h0, wv}, {1'h0, rows[i].ew});
      win(rows[i].w, rows[i].c, 1'h0);
      cyc(5);
      chk({2'h0, on}, {2'h0, rows[i].eo});
      cyc(1);
      chk({1'h0, st}, {1'h0, rows[i].es});
      cyc(12);
    end
    @(posedge clk);
    {sr, mn, md} <= {1'h0, 13'h0004, 13'h0600};
    cyc(14);
    win(1'h1, 1'h0, 1'h0);
    cyc(11);
    chk({1'h0, st}, {1'h0, STR_WR});
    cyc(1);
    chk({1'h0, st}, {1'h0, STR_NOM});
    win(1'h1, 1'h1, 1'h0);
    cyc(9);
    chk({1'h0, st}, {1'h0, STR_WR});
    cyc(1);
    chk({1'h0, st}, {1'h0, STR_NOM});
    @(posedge clk);
    al <= 5'h02;
    cyc(8);
    win(1'h0, 1'h0, 1'h0);
    cyc(6);
    chk({2'h0, on}, 3'h0);
    cyc(1);
    chk({2'h0, on}, 3'h1);
    @(posedge clk);
    al <= 5'h00;
    cyc(12);
    win(1'h0, 1'h0, 1'h1);
    for (k = 0; k < 8 && hv !== 1'h1; k++) cyc(1);
    chk({2'h0, hv}, 3'h1);
    cyc(8);
    win(1'h0, 1'h0, 1'h0);
    cyc(5);
    @(posedge clk) dq <= 1'h1;
    @(posedge clk) dq <= 1'h0;
    #1 chk({2'h0, on}, 3'h0);
    cyc(2);
    chk({2'h0, on}, 3'h1);
    cyc(10);
    @(posedge clk);
    {pd, mf, md, al} <= {1'h1, 13'h0000, 13'h0000, 5'h05};
    cyc(3);
    win(1'h0, 1'h0, 1'h0);
    cyc(3);
    chk({1'h0, on, av}, 3'h3);
    finish_test();
  end
endmodule
